/* File: common/lcec_pkg.sv */
// package: constants and types of the logic controller execution core
package lcec_pkg;
   // ----------------------------------------------------------------
   // instruction word layout
   // ----------------------------------------------------------------
   localparam int INSTR_W      = 16;
   localparam int PARITY_W     = 2;
   localparam int OPER_LSB     = 0;   // operand field [9:0]
   localparam int OPER_W       = 10;
   localparam int MOD_POS      = 10;  // inversion flag
   localparam int OPC_LSB      = 11;  // operation field [13:11]
   localparam int OPC_W        = 3;
   localparam int PAR_LO_POS   = 14;  // even parity over bits [6:0]
   localparam int PAR_HI_POS   = 15;  // even parity over bits [13:7]
   // ----------------------------------------------------------------
   // address map of the shared bus
   // ----------------------------------------------------------------
   localparam int ADDR_W       = 10;
   localparam int CHAN_PER_CARD= 8;
   localparam int IO_CHANNELS  = 256;
   localparam int IO_CARDS     = IO_CHANNELS / CHAN_PER_CARD;
   localparam logic [9:0] IO_BASE   = 10'h000;
   localparam logic [9:0] DATA_BASE = 10'h100;
   localparam int PC_W         = 11;
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [7:0]  ACC_RESET = 8'h00;
   // ----------------------------------------------------------------
   // operations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_AND   = 3'h1,
      OP_OR    = 3'h2,
      OP_WRITE = 3'h3,
      OP_BREAD = 3'h4,
      OP_BAND  = 3'h5,
      OP_BOR   = 3'h6,
      OP_BWRITE= 3'h7
   } lcec_op_type;
   typedef enum logic [5:0] {
      ST_FETCH  = 6'h01,
      ST_LOAD   = 6'h02,
      ST_OPER   = 6'h04,
      ST_EXEC   = 6'h08,
      ST_STORE  = 6'h10,
      ST_HALT   = 6'h20
   } lcec_state_type;
endpackage : lcec_pkg

/* File: hw/lcec_flag_mem.sv */
// result flag memory: one bit per program step, registered read port
`timescale 1ns/1ps
module lcec_flag_mem
   import lcec_pkg::*;
#(
   parameter int AW = 11
)(
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic          i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic               o_rdata
);
   logic mem [0:(1<<AW)-1];
   logic rdata_q;

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      rdata_q <= mem[i_raddr];
   end

   assign o_rdata = rdata_q;
endmodule : lcec_flag_mem

/* File: hw/lcec_core.sv */
// execution core: fetch, operand load, accumulate, store and memory check
// ----------------------------------------------------------------
// Operation
// [R1] Step one of each instruction reads the op code from program memory into the holding register.
// [R2] Step two reads the operand's I/O or data memory content into the operand data register.
// [R3] The result goes to the addressed I/O card, to data memory and to the result flag memory; the code writes card or data memory, as the address selects.
// [R4] The accumulator handles both single bits and whole bytes.
// [R5] Each memory and card answers only at its own fixed addresses on the shared bus.
// [R6] An instruction word is 16 bits, two of them parity over the other fourteen.
// [R7] Parity and battery health are checked all the time the core runs.
// [R8] A parity error or low battery drops the healthy lamp, raises the alarm and stops at once.
// [R9] I/O space is 256 channels in cards of eight channels each.
// [R10] A monitor may read program, flag, I/O and data memory while the program runs; the core gives a monitor port to the flag memory only.
// [R11] An instruction has operation, modification and operand fields; modification inverts the bit.
// [R12] The loader edits the program only in the stopped programming state; reads may run.
// [R13] After a memory fault the core stays halted with the alarm set until reset.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module lcec_core
   import lcec_pkg::*;
#(
   parameter int STEPS = 2048
)(
   input  wire logic                I_CLOCK,
   input  wire logic                I_ARST_N,
   input  wire logic                I_RUN,
   input  wire logic [INSTR_W-1:0]  I_PROG_DATA,
   input  wire logic                I_BATT_LOW,
   input  wire logic [7:0]          I_BUS_RDATA,
   input  wire logic [PC_W-1:0]     I_MON_ADDR,
   output logic      [PC_W-1:0]     O_PROG_ADDR,
   output logic      [ADDR_W-1:0]   O_BUS_ADDR,
   output logic                     O_IO_SEL,
   output logic                     O_DATA_SEL,
   output logic                     O_BUS_WE,
   output logic      [7:0]          O_BUS_WDATA,
   output logic                     O_FLAG_MON,
   output logic                     O_EDIT_STOP,
   output logic                     O_MEM_HEALTHY,
   output logic                     O_ALARM,
   output logic                     O_STEP_DONE
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic parity_ok(input logic [INSTR_W-1:0] w);
      parity_ok = (^w[6:0] == w[PAR_LO_POS]) && (^w[13:7] == w[PAR_HI_POS]); // R6
   endfunction : parity_ok

   function automatic logic is_io(input logic [ADDR_W-1:0] a);
      is_io = (a < DATA_BASE); // R5 R9
   endfunction : is_io

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] run_s_q, batt_s_q;
   logic [INSTR_W-1:0] prog_s1_q, prog_s2_q;
   logic [7:0] rd_s1_q, rd_s2_q;
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         run_s_q   <= 2'h0;
         batt_s_q  <= 2'h0;
         prog_s1_q <= 16'h0000;
         prog_s2_q <= 16'h0000;
         rd_s1_q   <= 8'h00;
         rd_s2_q   <= 8'h00;
      end else begin
         run_s_q   <= {run_s_q[0], I_RUN};
         batt_s_q  <= {batt_s_q[0], I_BATT_LOW};
         prog_s1_q <= I_PROG_DATA;
         prog_s2_q <= prog_s1_q;
         rd_s1_q   <= I_BUS_RDATA;
         rd_s2_q   <= rd_s1_q;
      end
   end
   wire logic run  = run_s_q[1];
   wire logic batt = batt_s_q[1];

   // ----------------------------------------------------------------
   // sequencer and accumulator
   // ----------------------------------------------------------------
   lcec_state_type         state_q, state_d;
   logic [PC_W-1:0]        pc_q, pc_d;
   logic [OPC_W-1:0]       opcode_holding_register_q, opcode_holding_register_d;
   logic                   inv_q, inv_d;
   logic [OPER_W-1:0]      oper_q, oper_d;
   logic [7:0]             operand_data_register_q, operand_data_register_d;
   logic [7:0]             acc_q, acc_d;
   logic [ADDR_W-1:0]      addr_q, addr_d;
   logic                   iosel_q, iosel_d, dsel_q, dsel_d, we_q, we_d;
   logic [7:0]             wdata_q, wdata_d;
   logic                   fault_q, fault_d, done_q, done_d, stop_q, stop_d;
   logic                   settle_q, settle_d, healthy_q, healthy_d;
   logic                   flag_we;
   logic                   bit_in;
   lcec_op_type            op;

   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      opcode_holding_register_d = opcode_holding_register_q;
      inv_d   = inv_q;
      oper_d  = oper_q;
      operand_data_register_d  = operand_data_register_q;
      acc_d   = acc_q;
      addr_d  = addr_q;
      iosel_d = 1'b0;
      dsel_d  = 1'b0;
      we_d    = 1'b0;
      wdata_d = wdata_q;
      fault_d = fault_q | batt;                                  // R7 R13
      done_d  = 1'b0;
      stop_d  = !run || fault_q;                                 // R12
      settle_d = 1'b0;
      flag_we = 1'b0;
      op      = lcec_op_type'(opcode_holding_register_q);
      bit_in  = operand_data_register_q[oper_q[2:0]] ^ inv_q;                     // R11
      unique case (state_q)
         ST_FETCH: begin
            // program word needs two sync stages after the address moves
            if (run) begin
               settle_d = !settle_q;
               if (settle_q) state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (!parity_ok(prog_s2_q)) begin
               fault_d = 1'b1;                                   // R7
            end else begin
               opcode_holding_register_d = prog_s2_q[OPC_LSB +: OPC_W];            // R1
               inv_d   = prog_s2_q[MOD_POS];                     // R11
               oper_d  = prog_s2_q[OPER_LSB +: OPER_W];
               addr_d  = {prog_s2_q[9:3], 3'h0};                 // card byte address, R9
               iosel_d = is_io(prog_s2_q[9:0]);                  // R5
               dsel_d  = !is_io(prog_s2_q[9:0]);                 // R5
               state_d = ST_OPER;
            end
         end
         ST_OPER: begin
            iosel_d = iosel_q;
            dsel_d  = dsel_q;
            state_d = ST_EXEC;                                   // bus read settles
         end
         ST_EXEC: begin
            // read byte needs two sync stages after the select rose
            if (settle_q) begin
               operand_data_register_d  = rd_s2_q;                                // R2
               state_d = ST_STORE;
            end else begin
               settle_d = 1'b1;
               iosel_d  = iosel_q;
               dsel_d   = dsel_q;
            end
         end
         ST_STORE: begin
            unique case (op)                                     // R4
               OP_READ:  acc_d = {7'h00, bit_in};
               OP_AND:   acc_d = {7'h00, acc_q[0] & bit_in};
               OP_OR:    acc_d = {7'h00, acc_q[0] | bit_in};
               OP_BREAD: acc_d = inv_q ? ~operand_data_register_q : operand_data_register_q;
               OP_BAND:  acc_d = acc_q & (inv_q ? ~operand_data_register_q : operand_data_register_q);
               OP_BOR:   acc_d = acc_q | (inv_q ? ~operand_data_register_q : operand_data_register_q);
               OP_WRITE: begin
                  wdata_d = operand_data_register_q;
                  wdata_d[oper_q[2:0]] = acc_q[0] ^ inv_q;
                  we_d    = 1'b1;                                // R3
               end
               OP_BWRITE: begin
                  wdata_d = inv_q ? ~acc_q : acc_q;
                  we_d    = 1'b1;                                // R3
               end
            endcase
            iosel_d = is_io(oper_q);                             // R5
            dsel_d  = !is_io(oper_q);
            flag_we = 1'b1;                                      // R3
            done_d  = 1'b1;
            pc_d    = (pc_q == PC_W'(STEPS - 1)) ? PC_RESET : pc_q + 11'h001;
            state_d = ST_FETCH;
         end
         ST_HALT: begin
            state_d = ST_HALT;                                   // R13
         end
         default: state_d = ST_HALT;
      endcase
      if (fault_d) begin
         state_d = ST_HALT;                                      // R8
         we_d    = 1'b0;
         iosel_d = 1'b0;
         dsel_d  = 1'b0;
         flag_we = 1'b0;
         done_d  = 1'b0;
      end
      healthy_d = !fault_d;                                      // R8
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_q <= ST_FETCH;
         pc_q    <= PC_RESET;
         opcode_holding_register_q <= 3'h0;
         inv_q   <= 1'b0;
         oper_q  <= 10'h000;
         operand_data_register_q  <= ACC_RESET;
         acc_q   <= ACC_RESET;
         addr_q  <= IO_BASE;
         iosel_q <= 1'b0;
         dsel_q  <= 1'b0;
         we_q    <= 1'b0;
         wdata_q <= 8'h00;
         fault_q <= 1'b0;
         done_q  <= 1'b0;
         stop_q  <= 1'b1;
         settle_q  <= 1'b0;
         healthy_q <= 1'b1;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         opcode_holding_register_q <= opcode_holding_register_d;
         inv_q   <= inv_d;
         oper_q  <= oper_d;
         operand_data_register_q  <= operand_data_register_d;
         acc_q   <= acc_d;
         addr_q  <= addr_d;
         iosel_q <= iosel_d;
         dsel_q  <= dsel_d;
         we_q    <= we_d;
         wdata_q <= wdata_d;
         fault_q <= fault_d;
         done_q  <= done_d;
         stop_q  <= stop_d;
         settle_q  <= settle_d;
         healthy_q <= healthy_d;
      end
   end

   // ----------------------------------------------------------------
   // result flag memory, monitor port reads while running
   // ----------------------------------------------------------------
   lcec_flag_mem #(.AW(PC_W)) u_flags (
      .i_clk   (I_CLOCK),
      .i_we    (flag_we),
      .i_waddr (pc_q),
      .i_wdata (acc_d[0]),                                       // R3
      .i_raddr (I_MON_ADDR),                                     // R10
      .o_rdata (O_FLAG_MON)
   );

   assign O_PROG_ADDR   = pc_q;
   assign O_BUS_ADDR    = addr_q;
   assign O_IO_SEL      = iosel_q;
   assign O_DATA_SEL    = dsel_q;
   assign O_BUS_WE      = we_q;
   assign O_BUS_WDATA   = wdata_q;
   assign O_EDIT_STOP   = stop_q;
   assign O_MEM_HEALTHY = healthy_q;                             // R8
   assign O_ALARM       = fault_q;                               // R8
   assign O_STEP_DONE   = done_q;
endmodule : lcec_core

/* File: test/lcec_bus_model.sv */
// partner model: program memory card plus i/o cards and data memory on the shared bus
`timescale 1ns/1ps
module lcec_bus_model
   import lcec_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic [PC_W-1:0]     i_prog_addr,
   input  wire logic [ADDR_W-1:0]   i_addr,
   input  wire logic                i_io_sel,
   input  wire logic                i_data_sel,
   input  wire logic                i_we,
   input  wire logic [7:0]          i_wdata,
   output logic      [INSTR_W-1:0]  o_prog_data,
   output logic      [7:0]          o_rdata
);
   logic [INSTR_W-1:0] prog [0:7];
   logic [7:0]         mem  [0:127];
   logic [7:0]         last_q = 8'h5a;
   logic               sel;
   assign sel         = i_io_sel | i_data_sel;
   assign o_prog_data = prog[i_prog_addr[2:0]];
   // released bus shows the inverse of the last byte, not a held value
   assign o_rdata     = sel ? mem[i_addr[9:3]] : ~last_q;
   always @(posedge i_clk) begin
      if (sel) last_q <= mem[i_addr[9:3]];
      if (sel && i_we) mem[i_addr[9:3]] <= i_wdata;
   end
endmodule : lcec_bus_model

/* File: test/lcec_core_asserts.sv */
// checker: port-level timing of the execution core
`timescale 1ns/1ps
module lcec_core_asserts
   import lcec_pkg::*;
#(
   parameter int STEPS = 2048
)(
   input  wire logic                I_CLOCK,
   input  wire logic                I_ARST_N,
   input  wire logic                I_BATT_LOW,
   input  wire logic [PC_W-1:0]     O_PROG_ADDR,
   input  wire logic [ADDR_W-1:0]   O_BUS_ADDR,
   input  wire logic                O_IO_SEL,
   input  wire logic                O_DATA_SEL,
   input  wire logic                O_BUS_WE,
   input  wire logic                O_MEM_HEALTHY,
   input  wire logic                O_ALARM,
   input  wire logic                O_STEP_DONE
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_ARST_N);
   we_one_cycle_a: assert property (O_BUS_WE |=> !O_BUS_WE)
      else $error("write strobe longer than one cycle");
   we_selected_a: assert property (O_BUS_WE |-> (O_IO_SEL || O_DATA_SEL))
      else $error("write without a selected target");
   io_space_a: assert property (O_IO_SEL |-> !O_DATA_SEL && O_BUS_ADDR < DATA_BASE)
      else $error("i/o select outside i/o space");
   data_space_a: assert property (O_DATA_SEL |-> O_BUS_ADDR >= DATA_BASE)
      else $error("data select below data space");
   card_align_a: assert property ((O_IO_SEL || O_DATA_SEL) |-> O_BUS_ADDR[2:0] == 3'h0)
      else $error("bus address not on a card byte");
   step_spacing_a: assert property (O_STEP_DONE |=> !O_STEP_DONE [*4])
      else $error("steps closer than five cycles");
   pc_advance_a: assert property (O_STEP_DONE |-> O_PROG_ADDR == (($past(O_PROG_ADDR)
      == PC_W'(STEPS-1)) ? '0 : $past(O_PROG_ADDR) + 1'b1))
      else $error("step counter did not advance");
   fault_halt_a: assert property (O_ALARM |-> !O_BUS_WE && !O_STEP_DONE && !O_MEM_HEALTHY)
      else $error("activity or healthy lamp after fault");
   alarm_sticky_a: assert property (O_ALARM |=> O_ALARM && $stable(O_PROG_ADDR))
      else $error("halt left without reset");
   batt_alarm_a: assert property (I_BATT_LOW |-> ##[0:6] O_ALARM)
      else $error("low battery not alarmed");
endmodule : lcec_core_asserts
bind lcec_core lcec_core_asserts #(.STEPS(STEPS)) u_chk (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N),
   .I_BATT_LOW(I_BATT_LOW), .O_PROG_ADDR(O_PROG_ADDR), .O_BUS_ADDR(O_BUS_ADDR),
   .O_IO_SEL(O_IO_SEL), .O_DATA_SEL(O_DATA_SEL), .O_BUS_WE(O_BUS_WE),
   .O_MEM_HEALTHY(O_MEM_HEALTHY), .O_ALARM(O_ALARM), .O_STEP_DONE(O_STEP_DONE));

/* File: test/logic_controller_execution_core_test.sv */
// testbench: looping program, monitor reads, parity and battery faults
`timescale 1ns/1ps
module logic_controller_execution_core_test;
   import lcec_pkg::*;
   logic               clk = 1'b0, arst_n = 1'b0, run = 1'b0, batt_low = 1'b0;
   logic [PC_W-1:0]    mon_addr = '0, prog_addr, pa;
   logic [INSTR_W-1:0] prog_data;
   logic [ADDR_W-1:0]  bus_addr;
   logic [7:0]         rdata, wdata;
   logic               io_sel, data_sel, bus_we, flag_mon, edit_stop, healthy, alarm, done;
   int                 bad_count = 0, num_checks = 0, cycles = 0;
   always #2.5 clk = ~clk;
   lcec_core #(.STEPS(8)) DUT (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_RUN(run),
      .I_PROG_DATA(prog_data), .I_BATT_LOW(batt_low), .I_BUS_RDATA(rdata),
      .I_MON_ADDR(mon_addr), .O_PROG_ADDR(prog_addr), .O_BUS_ADDR(bus_addr),
      .O_IO_SEL(io_sel), .O_DATA_SEL(data_sel), .O_BUS_WE(bus_we), .O_BUS_WDATA(wdata),
      .O_FLAG_MON(flag_mon), .O_EDIT_STOP(edit_stop), .O_MEM_HEALTHY(healthy),
      .O_ALARM(alarm), .O_STEP_DONE(done));
   lcec_bus_model u_mem (.i_clk(clk), .i_prog_addr(prog_addr), .i_addr(bus_addr),
      .i_io_sel(io_sel), .i_data_sel(data_sel), .i_we(bus_we), .i_wdata(wdata),
      .o_prog_data(prog_data), .o_rdata(rdata));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   function automatic logic [15:0] instr(input logic [2:0] op, input logic inv,
                                         input logic [9:0] opnd);
      logic [13:0] w;
      w = {op, inv, opnd};
      return {^w[13:7], ^w[6:0], w};
   endfunction : instr
   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t bit got %b expected %b", $time, got, exp);
      end
   endtask : check_bit
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t byte got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic stop_test();
      if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic do_reset();
      @(negedge clk);
      arst_n = 1'b0;
      run    = 1'b0;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
   endtask : do_reset
   task automatic wait_steps(input int n);
      int k;
      k = 0;
      for (int c = 0; c < 20 * n && k < n; c++) begin
         @(negedge clk);
         if (done === 1'b1) k++;
      end
      check_bit(k == n, 1'b1);
   endtask : wait_steps
   // halts, stays halted with pc frozen, then reset clears it
   task automatic wait_alarm();
      for (int c = 0; c < 40 && alarm !== 1'b1; c++) @(negedge clk);
      check_bit(alarm, 1'b1);
      check_bit(healthy, 1'b0);
      pa = prog_addr;
      repeat (20) @(negedge clk);
      check_bit(prog_addr === pa && alarm === 1'b1, 1'b1);
      do_reset();
      @(negedge clk);
      check_bit(alarm === 1'b0 && healthy === 1'b1, 1'b1);
   endtask : wait_alarm
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic program_run();
      logic [7:0] exp_flags;
      exp_flags = 8'b1111_1011;
      check_bit(edit_stop, 1'b1);
      u_mem.mem[7'h20] = 8'ha5;
      u_mem.mem[1]     = 8'h00;
      u_mem.mem[2]     = 8'h18;
      u_mem.prog[0] = instr(OP_BREAD, 1'b0, 10'h100);
      u_mem.prog[1] = instr(OP_BWRITE, 1'b0, 10'h008);
      u_mem.prog[2] = instr(OP_READ, 1'b1, 10'h013);
      u_mem.prog[3] = instr(OP_OR, 1'b0, 10'h014);
      u_mem.prog[4] = instr(OP_WRITE, 1'b1, 10'h105);
      u_mem.prog[5] = instr(OP_AND, 1'b0, 10'h014);
      for (int i = 6; i < 8; i++) u_mem.prog[i] = instr(OP_READ, 1'b0, 10'h013);
      run = 1'b1;
      wait_steps(24);
      check_bit(edit_stop, 1'b0);
      for (int i = 0; i < 8; i++) begin
         mon_addr = PC_W'(i);
         @(negedge clk);
         check_bit(flag_mon, exp_flags[i]);
      end
      check_byte(u_mem.mem[7'h20], 8'h85);
      check_byte(u_mem.mem[1], 8'h85);
      check_byte(u_mem.mem[2], 8'h18);
   endtask : program_run
   task automatic parity_fault();
      do_reset();
      u_mem.prog[3] = u_mem.prog[3] ^ 16'h8000;
      run = 1'b1;
      wait_alarm();
      u_mem.prog[3] = u_mem.prog[3] ^ 16'h8000;
   endtask : parity_fault
   task automatic battery_low();
      run = 1'b1;
      wait_steps(2);
      batt_low = 1'b1;
      repeat (2) @(negedge clk);
      batt_low = 1'b0;
      wait_alarm();
   endtask : battery_low
   initial begin
      do_reset();
      program_run();
      parity_fault();
      battery_low();
      stop_test();
   end
endmodule : logic_controller_execution_core_test
